//--- hw/adcs_sequencer.sv
// Serial interface and conversion sequencer of a four-channel 8-bit converter
`timescale 1ns/100ps
`include "adcs_regs.svh"

module adcs_sequencer (
    input wire logic i_clk,                       // Core clock, 250 MHz
    input wire logic i_rst_b,                     // Power-up reset, active low
    input wire logic i_sclk,                      // Shift clock from host
    input wire logic i_cs_b,                      // Frame select, active low
    input wire logic i_din,                       // Serial control input
    output logic o_dout,                          // Serial result output
    output logic o_dout_oe_b,                     // Result output enable, low drives
    input wire logic i_code_valid,                // Sample code offered
    input wire logic [7:0] i_code,                // Sample code for a conversion
    output logic o_code_ready,                    // Sample buffer has room
    output adcs_pkg::adcs_conv_t o_conv,          // Last conversion report
    output logic o_conv_valid,                    // One-cycle pulse per conversion
    output adcs_pkg::adcs_status_t o_status       // Frame and converter state
);
    import adcs_pkg::*;

    // ------------------------------------------------------------------------
    // Link clocks
    // ------------------------------------------------------------------------
    logic sclk_rise_clk;
    logic sclk_fall_clk;
    logic frame_on;

    // Shift clock held high outside a frame; select fall with clock low
    // makes the internal falling edge at once
    assign sclk_rise_clk = i_sclk | i_cs_b;
    assign sclk_fall_clk = ~sclk_rise_clk;
    assign frame_on = ~i_cs_b;

    // Link clear: frame end or power-up reset. Without the reset term the
    // link registers would stay unknown after power-up until a first frame
    // had ended, and the result pin would not be known to be released.
    logic link_clr;
    assign link_clr = i_cs_b | ~i_rst_b;

    // Hazard of the gated clock: a select edge that lands close to a shift
    // clock edge gives a short internal pulse. The counters then see one
    // edge more or less, and capture slips by one cycle. The host keeps
    // the two edges apart; nothing here can repair a frame that it cuts.

    // ------------------------------------------------------------------------
    // Link-side declarations
    // ------------------------------------------------------------------------
    logic [3:0] fall_cnt_r;
    logic [3:0] fall_cnt_nxt;
    adcs_mode_t mode_r;
    adcs_mode_t mode_nxt;
    logic pdown_r;
    logic track_r;
    logic [7:0] code_r;
    logic [7:0] held_code;
    logic [1:0] cur_chan_r;
    logic take_tgl_r;
    adcs_conv_t rep_r;
    logic stage_full_lk;
    logic [3:0] rise_cnt_r;
    logic [6:0] ctrl_shift_r;
    logic [7:0] ctrl_word;
    logic [1:0] next_chan_r;
    logic [2:0] bit_idx;

    // ------------------------------------------------------------------------
    // Core-side declarations
    // ------------------------------------------------------------------------
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic stage_full_r;
    logic [7:0] stage_r;
    logic [3:0] core_sync;
    logic tgl_seen_r;
    logic take_ev;

    // ------------------------------------------------------------------------
    // Falling-edge side: phase count and converter mode
    // ------------------------------------------------------------------------

    // Count 0 stands for both "before the first fall" and "after the
    // sixteenth fall", so back-to-back conversions need no extra state
    assign fall_cnt_nxt = fall_cnt_r + 4'h1;

    // Mode sequence over one conversion
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            ADCS_PDOWN: begin
                mode_nxt = ADCS_TRACK;
            end
            ADCS_TRACK: begin
                if (fall_cnt_r == `ADCS_TRACK_LAST) begin
                    mode_nxt = ADCS_HOLD;
                end
            end
            ADCS_HOLD: begin
                if (fall_cnt_r == `ADCS_HOLD_LAST) begin
                    mode_nxt = ADCS_PDOWN;
                end
            end
            default: begin
                mode_nxt = ADCS_PDOWN;
            end
        endcase
    end

    // Phase and mode; a high frame select ends everything at once.
    // A conversion cut short by the select rising is dropped here: the
    // count and mode restart, so the next frame opens with a fresh track.
    always_ff @(posedge sclk_fall_clk or posedge link_clr) begin
        if (link_clr) begin
            fall_cnt_r <= 4'h0;
            mode_r <= ADCS_PDOWN;
            pdown_r <= 1'b1;
            track_r <= 1'b0;
        end else begin
            fall_cnt_r <= fall_cnt_nxt;
            mode_r <= mode_nxt;
            pdown_r <= (mode_nxt == ADCS_PDOWN);
            track_r <= (mode_nxt == ADCS_TRACK);
        end
    end

    // Code taken at the hold edge: the staged sample if one was ready
    assign held_code = stage_full_lk ? stage_r : 8'h00;

    // Held result for shifting out; loaded once per conversion at the
    // hold edge and left alone while its bits leave on the pin
    always_ff @(posedge sclk_fall_clk or posedge link_clr) begin
        if (link_clr) begin
            code_r <= 8'h00;
        end else if (mode_r == ADCS_TRACK && mode_nxt == ADCS_HOLD) begin
            code_r <= held_code;
        end
    end

    // ------------------------------------------------------------------------
    // Result output
    // ------------------------------------------------------------------------

    // Falls 5 to 12 carry bits 7 down to 0; all others send zero
    assign bit_idx = 3'(`ADCS_DATA_LAST - fall_cnt_nxt);

    // Output data changes only after falling edges, so the host has a
    // whole low phase of setup before it samples on the rise.
    // Slots outside the eight data bits send zero, never stale data.
    always_ff @(posedge sclk_fall_clk or posedge link_clr) begin
        if (link_clr) begin
            o_dout <= 1'b0;
        end else if (fall_cnt_nxt >= `ADCS_DATA_FIRST && fall_cnt_nxt <= `ADCS_DATA_LAST) begin
            o_dout <= code_r[bit_idx];
        end else begin
            o_dout <= 1'b0;
        end
    end

    // Driver released at once when frame select rises, enabled by the
    // first internal falling edge of the frame
    always_ff @(posedge sclk_fall_clk or posedge link_clr) begin
        if (link_clr) begin
            o_dout_oe_b <= 1'b1;
        end else begin
            o_dout_oe_b <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Channel pipeline and conversion report
    // ------------------------------------------------------------------------

    // Channel pipeline: the word of one conversion only reaches the
    // multiplexer at the first fall of the next one. Both stages keep
    // their value across frames, so only a power-up reset returns them
    // to the first input.

    // Channel of the running conversion; survives between frames
    always_ff @(posedge sclk_fall_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cur_chan_r <= `ADCS_CHAN_RESET;
        end else if (!i_cs_b && mode_r == ADCS_PDOWN) begin
            cur_chan_r <= next_chan_r;
        end
    end

    // Report and toggle at each hold edge; held until the next one
    always_ff @(posedge sclk_fall_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            take_tgl_r <= 1'b0;
            rep_r <= '0;
        end else if (!i_cs_b && mode_r == ADCS_TRACK && mode_nxt == ADCS_HOLD) begin
            take_tgl_r <= ~take_tgl_r;
            rep_r.fresh <= stage_full_lk;
            rep_r.chan <= cur_chan_r;
            rep_r.code <= held_code;
        end
    end

    // Staged-sample flag brought into the falling-edge domain
    adcs_sync #(
        .W(1)
    ) u_sync_link (
        .i_clk(sclk_fall_clk),
        .i_rst_b(frame_on),
        .i_d(stage_full_r),
        .o_q(stage_full_lk)
    );

    // ------------------------------------------------------------------------
    // Rising-edge side: control word capture
    // ------------------------------------------------------------------------

    // Rise count restarts with every frame. The count wraps after the
    // sixteenth rise, so each conversion of a long frame takes its own
    // control word on its first eight rises without any extra state.
    always_ff @(posedge sclk_rise_clk or posedge link_clr) begin
        if (link_clr) begin
            rise_cnt_r <= 4'h0;
            ctrl_shift_r <= 7'h00;
        end else begin
            rise_cnt_r <= rise_cnt_r + 4'h1;
            if (rise_cnt_r <= `ADCS_CAPTURE_LAST) begin
                ctrl_shift_r <= {ctrl_shift_r[5:0], i_din};
            end
        end
    end

    // Whole word as of the eighth rise, MSB first
    assign ctrl_word = {ctrl_shift_r, i_din};

    // Channel for the next conversion; the top select bit and the
    // remaining bits are not looked at
    always_ff @(posedge sclk_rise_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            next_chan_r <= `ADCS_CHAN_RESET;
        end else if (!i_cs_b && rise_cnt_r == `ADCS_CAPTURE_LAST) begin
            next_chan_r <= ctrl_word[`ADCS_CHAN_SEL_MID:`ADCS_CHAN_SEL_LO];
        end
    end

    // ------------------------------------------------------------------------
    // Core side: sample buffer and staging
    // ------------------------------------------------------------------------

    // Handshake with the link: the stage register is filled from the
    // buffer only while its flag is low, and the link reads it only after
    // the flag has passed two of its own flip-flops. The flag is lowered
    // when a report says that the staged code was used, so a code is
    // never changed under the link and never used twice.

    // Sample codes wait here until conversions use them
    adcs_fifo #(
        .W(`ADCS_CODE_WIDTH),
        .DEPTH(`ADCS_FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_code_valid),
        .i_in_data(i_code),
        .o_in_ready(o_code_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(~stage_full_r)
    );

    // Link levels and the report toggle brought into the core domain
    adcs_sync #(
        .W(4)
    ) u_sync_core (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_d({frame_on, pdown_r, track_r, take_tgl_r}),
        .o_q(core_sync)
    );

    assign take_ev = core_sync[0] ^ tgl_seen_r;

    // Stage register is stable while full; the link reads it then
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stage_full_r <= 1'b0;
            stage_r <= 8'h00;
        end else if (!stage_full_r && fifo_valid) begin
            stage_full_r <= 1'b1;
            stage_r <= fifo_data;
        end else if (take_ev && rep_r.fresh) begin
            stage_full_r <= 1'b0;
        end
    end

    // Report capture; the link word has been stable for many cycles.
    // Only the toggle crosses through flip-flops; the report word is read
    // once the toggle has been seen, long after its last change.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tgl_seen_r <= 1'b0;
            o_conv <= '0;
            o_conv_valid <= 1'b0;
        end else begin
            tgl_seen_r <= core_sync[0];
            o_conv_valid <= take_ev;
            if (take_ev) begin
                o_conv <= rep_r;
            end
        end
    end

    // Converter state seen from the core. The three levels are brought
    // over one by one, so track is only shown while the frame level is
    // seen as well; outside a frame the converter is powered down.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status <= '0;
        end else begin
            o_status.frame_active <= core_sync[3];
            o_status.power_down <= core_sync[2] | ~core_sync[3];
            o_status.track <= core_sync[1] & core_sync[3];
        end
    end
endmodule

//--- hw/adcs_regs.svh
// Constants of the serial conversion sequencer: control word layout and cycle counts
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// ----------------------------------------------------------------------------
// Control word layout
// ----------------------------------------------------------------------------
`define ADCS_CTRL_WIDTH 8
`define ADCS_CHAN_SEL_HI 5
`define ADCS_CHAN_SEL_MID 4
`define ADCS_CHAN_SEL_LO 3
`define ADCS_CHAN_RESET 2'h0

// ----------------------------------------------------------------------------
// Conversion timing in shift-clock cycles
// ----------------------------------------------------------------------------
`define ADCS_CONV_CYCLES 16
`define ADCS_TRACK_LAST 4'h3
`define ADCS_HOLD_LAST 4'hf
`define ADCS_DATA_FIRST 4'h5
`define ADCS_DATA_LAST 4'hc
`define ADCS_CAPTURE_LAST 4'h7
`define ADCS_CODE_WIDTH 8

// ----------------------------------------------------------------------------
// Sample buffer
// ----------------------------------------------------------------------------
`define ADCS_FIFO_DEPTH 16

`endif

//--- hw/adcs_pkg.sv
// Types shared by the serial conversion sequencer
package adcs_pkg;

    // Converter phase within one 16-cycle conversion
    typedef enum logic [1:0] {
        ADCS_PDOWN,
        ADCS_TRACK,
        ADCS_HOLD
    } adcs_mode_t;

    // Report of one conversion, handed from the link side to the core side
    typedef struct packed {
        logic fresh;
        logic [1:0] chan;
        logic [7:0] code;
    } adcs_conv_t;

    // Core-side view of the converter state
    typedef struct packed {
        logic frame_active;
        logic power_down;
        logic track;
    } adcs_status_t;

endpackage

//--- hw/adcs_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/100ps
module adcs_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,            // Destination clock
    input wire logic i_rst_b,          // Asynchronous reset, active low
    input wire logic [W-1:0] i_d,      // Level from the other domain
    output logic [W-1:0] o_q           // Synchronised level
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= '0;
            o_q <= '0;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule

//--- hw/adcs_fifo.sv
// Sample FIFO with registered read data and valid/ready on both sides
`timescale 1ns/100ps
module adcs_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,            // Core clock
    input wire logic i_rst_b,          // Asynchronous reset, active low
    input wire logic i_in_valid,       // Write request
    input wire logic [W-1:0] i_in_data, // Write data
    output logic o_in_ready,           // Space available
    output logic o_out_valid,          // Read data valid
    output logic [W-1:0] o_out_data,   // Registered read data
    input wire logic i_out_ready       // Drain side accepts
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push;
    logic pop;

    // Memory moves a word to the output register when that is free
    assign push = i_in_valid && o_in_ready;
    assign pop = (cnt_r != '0) && (!o_out_valid || i_out_ready);
    assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wp_r] <= i_in_data;
        end
    end

    // Pointers, fill count and full flag
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            o_in_ready <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            o_in_ready <= (cnt_nxt != DEPTH[AW:0]);
        end
    end

    // Output register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end else if (pop) begin
            o_out_valid <= 1'b1;
            o_out_data <= mem_r[rp_r];
        end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
        end
    end
endmodule

//--- test/adcs_sequencer_sva.sv
// Concurrent checks on the conversion sequencer ports
`timescale 1ns/100ps
module adcs_sequencer_sva (
    input wire logic i_clk,                        // Core clock
    input wire logic i_rst_b,                      // Reset, active low
    input wire logic i_sclk,                       // Shift clock
    input wire logic i_cs_b,                       // Frame select, active low
    input wire logic o_dout,                       // Result output
    input wire logic o_dout_oe_b,                  // Result enable, low drives
    input wire logic o_conv_valid,                 // Report pulse
    input wire adcs_pkg::adcs_conv_t o_conv,       // Report
    input wire adcs_pkg::adcs_status_t o_status    // Converter state
);
    import adcs_pkg::*;

    // ------------------------------------------------------------------
    // Pin, state and report relations
    // ------------------------------------------------------------------
    AST_OE_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_cs_b |-> o_dout_oe_b) else $error("result pin driven outside frame");
    AST_DOUT_QUIET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_cs_b |-> !o_dout) else $error("result pin not quiet outside frame");
    AST_OE_IN_FRAME: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
        !i_cs_b |-> !o_dout_oe_b) else $error("result pin floats in frame");
    AST_PDOWN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_cs_b && i_rst_b) [*5] |-> o_status.power_down && !o_status.track)
        else $error("not powered down outside frame");
    AST_FRAME_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_cs_b && i_rst_b) [*5] |-> !o_status.frame_active)
        else $error("frame seen while select high");
    AST_FRAME_ON: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!i_cs_b && i_rst_b) [*5] |-> o_status.frame_active)
        else $error("frame missed while select low");
    AST_MODE_EXCL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(o_status.track && o_status.power_down)) else $error("track while powered down");
    AST_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_conv_valid |=> !o_conv_valid) else $error("report pulse too long");
    AST_CONV_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !o_conv_valid |-> $stable(o_conv)) else $error("report changed without pulse");
    AST_STALE_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_conv_valid && !o_conv.fresh |-> o_conv.code == 8'h00)
        else $error("stale report carries a code");
endmodule

//--- test/adcs_host_model.sv
// Serial host model: frames, shift clock, control words and result capture
`timescale 1ns/100ps
module adcs_host_model (
    output logic o_sclk,                 // Shift clock, 12 ns, still outside frames
    output logic o_cs_b,                 // Frame select, active low
    output logic o_din,                  // Control word, changed after falls
    input wire logic i_dout,             // Result from device
    input wire logic i_dout_oe_b         // Result enable, low drives
);
    logic [7:0] ctrl [20];
    logic [15:0] res [20];
    logic oe_bad;

    // Idle levels
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_din = 1'b0;
        oe_bad = 1'b0;
    end

    // One frame of n whole conversions; sclk parks high or low after it
    task automatic run_frame(input int n, input bit end_hi);
        int j;
        #1; // Link edges kept off the core clock edges
        o_cs_b = 1'b0;
        if (o_sclk) begin
            #6;
            o_sclk = 1'b0;
        end
        for (int k = 0; k < 16 * n; k++) begin
            j = k % 16;
            o_din = (j < 8) ? ctrl[k / 16][7 - j] : ~o_din;
            #6;
            o_sclk = 1'b1;
            res[k / 16][15 - j] = i_dout;
            if (i_dout_oe_b !== 1'b0) oe_bad = 1'b1;
            #6;
            if (k < 16 * n - 1) o_sclk = 1'b0;
        end
        o_cs_b = 1'b1;
        o_din = ~o_din;
        if (!end_hi) begin
            #6;
            o_sclk = 1'b0;
        end
    endtask
endmodule

//--- test/adcs_sequencer_tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/100ps
module adcs_sequencer_tb;
    import adcs_pkg::*;
    typedef struct packed {logic [7:0] word; logic [7:0] code; logic [1:0] chan;} adcs_row_t;
    logic i_clk, i_rst_b, i_code_valid, o_code_ready, o_conv_valid, o_dout, o_dout_oe_b;
    wire i_sclk, i_cs_b, i_din;
    logic [7:0] i_code;
    adcs_conv_t o_conv;
    adcs_status_t o_status;
    adcs_conv_t conv_q [$];
    logic [7:0] code_q [$];
    logic [1:0] chan_cur;
    int failures, n_compared, n;
    adcs_row_t rows [5] = '{'{8'h08, 8'ha5, 2'h0}, '{8'hf7, 8'h01, 2'h1},
        '{8'hdf, 8'hff, 2'h2}, '{8'h27, 8'h80, 2'h3}, '{8'h18, 8'h3c, 2'h0}};

    adcs_sequencer uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_cs_b(i_cs_b),
        .i_din(i_din), .o_dout(o_dout), .o_dout_oe_b(o_dout_oe_b),
        .i_code_valid(i_code_valid), .i_code(i_code), .o_code_ready(o_code_ready),
        .o_conv(o_conv), .o_conv_valid(o_conv_valid), .o_status(o_status));
    adcs_host_model host (.o_sclk(i_sclk), .o_cs_b(i_cs_b), .o_din(i_din), .i_dout(o_dout),
        .i_dout_oe_b(o_dout_oe_b));

    // Core clock, 4 ns
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Collect conversion reports
    always @(posedge i_clk) begin
        if (o_conv_valid === 1'b1) conv_q.push_back(o_conv);
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Offer one code and wait, bounded, until it is taken
    task automatic push_code(input logic [7:0] c);
        int k;
        @(posedge i_clk);
        i_code_valid <= 1'b1;
        i_code <= c;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_code_ready !== 1'b1 && k < 50);
        i_code_valid <= 1'b0;
        code_q.push_back(c);
        if (k >= 50) begin
            failures++;
            give_verdict();
        end
    endtask

    // Run a frame and compare every conversion against the expected pipeline
    task automatic do_frame(input int n, input bit end_hi);
        logic [7:0] c;
        logic f;
        conv_q.delete();
        host.run_frame(n, end_hi);
        repeat (6) @(posedge i_clk);
        check("reports", 16'(conv_q.size()), 16'(n));
        for (int k = 0; k < n; k++) begin
            f = (code_q.size() > 0);
            c = f ? code_q.pop_front() : 8'h00;
            check("dout", host.res[k], {4'h0, c, 4'h0});
            check("report", {5'h0, conv_q[k]}, {5'h0, f, chan_cur, c});
            chan_cur = host.ctrl[k][4:3];
        end
        check("oe_frame", {15'h0, host.oe_bad}, 16'h0);
        check("oe_idle", {15'h0, o_dout_oe_b}, 16'h1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        i_rst_b = 1'b0;
        i_code_valid = 1'b0;
        i_code = 8'h00;
        failures = 0;
        n_compared = 0;
        chan_cur = 2'h0;
        repeat (5) @(posedge i_clk);
        check("reset", {o_conv_valid, o_code_ready, o_status, o_conv}, 16'h4000);
        i_rst_b <= 1'b1;
        // Ordinary single conversions, both idle clock levels
        for (int i = 0; i < 5; i++) begin
            push_code(rows[i].code);
            host.ctrl[0] = rows[i].word;
            repeat (10) @(posedge i_clk);
            do_frame(1, i[0]);
            check("chan", {14'h0, conv_q[0].chan}, {14'h0, rows[i].chan});
        end
        // Back-to-back conversions in one frame
        push_code(8'h5a);
        push_code(8'hc3);
        push_code(8'h0f);
        host.ctrl[0] = 8'h10;
        host.ctrl[1] = 8'h08;
        host.ctrl[2] = 8'h38;
        repeat (10) @(posedge i_clk);
        do_frame(3, 1'b1);
        // Fill the buffer until refused, then drain past empty
        @(posedge i_clk);
        i_code_valid <= 1'b1;
        i_code <= 8'h40;
        n = 0;
        repeat (40) begin
            @(posedge i_clk);
            if (o_code_ready === 1'b1) begin
                code_q.push_back(i_code);
                n++;
                i_code <= i_code + 8'h01;
            end
        end
        check("full", {15'h0, o_code_ready}, 16'h0);
        i_code_valid <= 1'b0;
        check("accepted", 16'(n), 16'h0012);
        for (int k = 0; k < 19; k++) host.ctrl[k] = (k == 18) ? 8'h18 : 8'h00;
        do_frame(19, 1'b0);
        // Second reset: channel pipeline back to the first input
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        chan_cur = 2'h0;
        push_code(8'h77);
        host.ctrl[0] = 8'h00;
        repeat (10) @(posedge i_clk);
        do_frame(1, 1'b0);
        give_verdict();
    end
endmodule

bind adcs_sequencer adcs_sequencer_sva chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_sclk(i_sclk), .i_cs_b(i_cs_b), .o_dout(o_dout), .o_dout_oe_b(o_dout_oe_b),
    .o_conv_valid(o_conv_valid), .o_conv(o_conv), .o_status(o_status));
